// File: hw/stl_dec_pkg.sv
package stl_dec_pkg;
	localparam int CLK_HZ = 50000000;
	localparam int CLK_KHZ = 50000;
	localparam int CLK_NS = 20;
	// -----------------------------------------------------------------
	// Register map and fields
	// -----------------------------------------------------------------
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] ERRCNT_OFS = 4'h8;
	localparam int MODE_LSB = 0;
	localparam int TIMING_BIT = 2;
	localparam int DINV_BIT = 3;
	localparam int CINV_BIT = 4;
	localparam int AUXDIG_BIT = 5;
	localparam logic [1:0] MODE_PROGRAM = 2'h0;
	localparam logic [1:0] MODE_REPEATER = 2'h1;
	localparam logic [1:0] MODE_AES = 2'h2;
	localparam logic [1:0] MODE_PCM = 2'h3;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	// -----------------------------------------------------------------
	// Audio formats and timing
	// -----------------------------------------------------------------
	localparam int SAMPLE_HZ = 32000;
	localparam int SAMPLE_BITS = 16;
	localparam logic [4:0] PCM_HALF_CYC = 5'(CLK_HZ / (SAMPLE_HZ * SAMPLE_BITS * 2 * 2));
	localparam int AES_CELL_KHZ = (SAMPLE_HZ / 1000) * 128;
	localparam logic [7:0] AES_LAST_FRAME = 8'hBF;
	localparam logic [7:0] AES_PRE_Z = 8'hE8;
	localparam logic [7:0] AES_PRE_X = 8'hE2;
	localparam logic [7:0] AES_PRE_Y = 8'hE4;
	localparam int LOCK_GAP_NS = 20000;
	localparam logic [10:0] LOCK_GAP_CYC = 11'(LOCK_GAP_NS / CLK_NS);
	localparam logic [3:0] LOCK_EDGES = 4'h8;
	localparam int ERR_HOLD_MS = 100;
	localparam int ERR_HOLD_CYC = ERR_HOLD_MS * (CLK_HZ / 1000);
endpackage

// File: hw/audio_if.sv
`timescale 1ns/100ps
// One stereo sample pair with its load strobe, from the top to a framer.
interface audio_if;
	logic [15:0] left;
	logic [15:0] right;
	logic load;
	modport src(output left, output right, output load);
	modport sink(input left, input right, input load);
endinterface

// File: hw/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// -----------------------------------------------------------------
	// Three stages per bit; a change counts once stages two and three agree.
	// -----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_r, s2_r, s3_r, q_nxt;
			// Stage one feeds stage two only, so no logic sees a metastable level.
			always_comb begin
				q_nxt = (s2_r == s3_r) ? s2_r : q[i];
			end
			always_ff @(posedge clock) begin
				if (rst) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
					s3_r <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					s1_r <= d[i];
					s2_r <= s1_r;
					s3_r <= s2_r;
					q[i] <= q_nxt;
				end
			end
		end
	endgenerate
endmodule

// File: hw/aes_framer.sv
`timescale 1ns/100ps
module aes_framer import stl_dec_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	audio_if.sink au,
	output logic aes_out
);
	logic [16:0] acc_r, acc_nxt;
	logic [5:0] cell_r, cell_nxt;
	logic sub_r, sub_nxt;
	logic [7:0] blk_r, blk_nxt;
	logic [15:0] hl_r, hl_nxt, hr_r, hr_nxt, cur_r, cur_nxt;
	logic lvl_r, lvl_nxt, pst_r, pst_nxt;
	logic tick;
	logic [31:0] word;
	logic [7:0] pre;

	// -----------------------------------------------------------------
	// Biphase-mark subframes, 64 cells each, 128 cells per sample period.
	// -----------------------------------------------------------------
	// The cell rate is made by a fractional accumulator, so cells jitter by
	// one clock but the average rate is exact.
	always_comb begin
		acc_nxt = acc_r + 17'(AES_CELL_KHZ);
		tick = 1'b0;
		if (acc_nxt >= 17'(CLK_KHZ)) begin
			acc_nxt = acc_nxt - 17'(CLK_KHZ);
			tick = 1'b1;
		end
		hl_nxt = au.load ? au.left : hl_r;
		hr_nxt = au.load ? au.right : hr_r;
		cell_nxt = cell_r;
		sub_nxt = sub_r;
		blk_nxt = blk_r;
		cur_nxt = cur_r;
		lvl_nxt = lvl_r;
		pst_nxt = pst_r;
		word = {^cur_r, 3'h0, cur_r, 12'h000};
		pre = sub_r ? AES_PRE_Y : ((blk_r == 8'h00) ? AES_PRE_Z : AES_PRE_X);
		if (tick) begin
			if (cell_r < 6'h08) begin
				lvl_nxt = pre[3'h7 - cell_r[2:0]] ^ pst_r;
			end else if (!cell_r[0]) begin
				lvl_nxt = !lvl_r;
			end else begin
				lvl_nxt = lvl_r ^ word[cell_r[5:1]];
			end
			cell_nxt = cell_r + 6'h01;
			if (cell_r == 6'h3F) begin
				pst_nxt = lvl_nxt;
				sub_nxt = !sub_r;
				cur_nxt = sub_r ? hl_r : hr_r;
				if (sub_r) begin
					blk_nxt = (blk_r == AES_LAST_FRAME) ? 8'h00 : blk_r + 8'h01;
				end
			end
		end
	end

	// Registers only.
	always_ff @(posedge clock) begin
		if (rst) begin
			acc_r <= 17'h00000;
			cell_r <= 6'h00;
			sub_r <= 1'b0;
			blk_r <= 8'h00;
			hl_r <= 16'h0000;
			hr_r <= 16'h0000;
			cur_r <= 16'h0000;
			lvl_r <= 1'b0;
			pst_r <= 1'b0;
		end else begin
			acc_r <= acc_nxt;
			cell_r <= cell_nxt;
			sub_r <= sub_nxt;
			blk_r <= blk_nxt;
			hl_r <= hl_nxt;
			hr_r <= hr_nxt;
			cur_r <= cur_nxt;
			lvl_r <= lvl_nxt;
			pst_r <= pst_nxt;
		end
	end

	assign aes_out = lvl_r;
endmodule

// File: hw/intf_mode_mux.sv
`timescale 1ns/100ps
module intf_mode_mux import stl_dec_pkg::*; #(
	parameter int unsigned ERR_HOLD_CYCLES = ERR_HOLD_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic link_data,
	input wire logic link_clk,
	input wire logic ext_data,
	input wire logic ext_clk,
	input wire logic decode_error,
	input wire logic [15:0] main_left,
	input wire logic [15:0] main_right,
	input wire logic main_load,
	input wire logic [15:0] aux_left,
	input wire logic [15:0] aux_right,
	input wire logic aux_load,
	output logic intf_data,
	output logic intf_clk,
	output logic intf_frame,
	output logic intf_oe,
	output logic relay_output,
	output logic aes_main_out,
	output logic aes_aux_out,
	output logic aux_digital,
	output logic channel_data,
	output logic lock_green,
	output logic lock_red,
	output logic error_led
);
	logic [1:0] mode_r, mode_nxt;
	logic timing_r, timing_nxt, dinv_r, dinv_nxt, cinv_r, cinv_nxt, auxdig_r, auxdig_nxt;
	logic wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic req, commit, ctrl_wr;
	logic link_data_s, link_clk_s, ext_data_s, ext_clk_s;
	logic sel_clk, sel_data, clk_edge, invalid;
	logic prev_clk_r, prev_clk_nxt, bit_r, bit_nxt;
	logic [10:0] gap_r, gap_nxt;
	logic [3:0] good_r, good_nxt;
	logic locked_r, locked_nxt, red_r, red_nxt;
	logic [22:0] hold_r, hold_nxt;
	logic [15:0] errcnt_r, errcnt_nxt;
	logic err_r, err_nxt;
	logic [15:0] pl_r, pl_nxt, pr_r, pr_nxt;
	logic [31:0] psh_r, psh_nxt;
	logic [4:0] pdiv_r, pdiv_nxt, pbit_r, pbit_nxt;
	logic pclk_r, pclk_nxt;
	logic id_r, ic_r, if_r, ioe_r, rel_r;
	logic id_nxt, ic_nxt, if_nxt, ioe_nxt, rel_nxt;
	logic aes_main, aes_aux;

	audio_if main_au();
	audio_if aux_au();
	assign main_au.left = main_left;
	assign main_au.right = main_right;
	assign main_au.load = main_load;
	assign aux_au.left = aux_left;
	assign aux_au.right = aux_right;
	assign aux_au.load = aux_load;
	// The main framer always runs so its stream is ready in every mode.
	aes_framer u_aes_main (.clock(clock), .rst(rst), .au(main_au.sink), .aes_out(aes_main));
	aes_framer u_aes_aux (.clock(clock), .rst(rst), .au(aux_au.sink), .aes_out(aes_aux));
	pin_sync #(.W(4)) u_sync (.clock(clock), .rst(rst), .d({ext_clk, ext_data, link_clk, link_data}),
		.q({ext_clk_s, ext_data_s, link_clk_s, link_data_s}));
	// -----------------------------------------------------------------
	// Avalon-MM slave: one wait cycle, then the answer for one cycle
	// -----------------------------------------------------------------
	assign req = avs_read || avs_write;
	assign commit = avs_write && !wait_r;
	assign ctrl_wr = commit && (avs_address == CTRL_OFS) && avs_byteenable[0];

	// Control bits change only at the edge that completes the write.
	always_comb begin
		wait_nxt = wait_r ? !req : 1'b1;
		rdata_nxt = rdata_r;
		mode_nxt = mode_r;
		timing_nxt = timing_r;
		dinv_nxt = dinv_r;
		cinv_nxt = cinv_r;
		auxdig_nxt = auxdig_r;
		if (ctrl_wr) begin
			mode_nxt = avs_writedata[MODE_LSB +: 2];
			timing_nxt = avs_writedata[TIMING_BIT];
			dinv_nxt = avs_writedata[DINV_BIT];
			cinv_nxt = avs_writedata[CINV_BIT];
			auxdig_nxt = avs_writedata[AUXDIG_BIT];
		end
		if (avs_read && wait_r) begin
			if (avs_address == CTRL_OFS) begin
				rdata_nxt = {26'h0, auxdig_r, cinv_r, dinv_r, timing_r, mode_r};
			end else if (avs_address == STATUS_OFS) begin
				rdata_nxt = {28'h0, err_r, invalid, locked_r, rel_r};
			end else if (avs_address == ERRCNT_OFS) begin
				rdata_nxt = {16'h0, errcnt_r};
			end else begin
				rdata_nxt = 32'h0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h0;
			{auxdig_r, cinv_r, dinv_r, timing_r, mode_r} <= CTRL_RESET;
		end else begin
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
			mode_r <= mode_nxt;
			timing_r <= timing_nxt;
			dinv_r <= dinv_nxt;
			cinv_r <= cinv_nxt;
			auxdig_r <= auxdig_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Timing source, data polarity and clock lock
	// -----------------------------------------------------------------
	assign sel_clk = timing_r ? (ext_clk_s ^ cinv_r) : link_clk_s;
	assign sel_data = (timing_r ? ext_data_s : link_data_s) ^ dinv_r;
	assign clk_edge = sel_clk && !prev_clk_r;
	assign invalid = timing_r && mode_r[0];

	// Lock needs a run of edges with no long gap; a change of timing source
	// or clock polarity restarts it, so the lamp goes red while relocking.
	always_comb begin
		prev_clk_nxt = sel_clk;
		bit_nxt = clk_edge ? sel_data : bit_r;
		gap_nxt = gap_r;
		good_nxt = good_r;
		locked_nxt = locked_r;
		if (ctrl_wr && ((avs_writedata[TIMING_BIT] != timing_r) || (avs_writedata[CINV_BIT] != cinv_r))) begin
			gap_nxt = 11'h000;
			good_nxt = 4'h0;
			locked_nxt = 1'b0;
		end else if (clk_edge) begin
			gap_nxt = 11'h000;
			if (good_r == LOCK_EDGES - 4'h1) begin
				locked_nxt = 1'b1;
			end else begin
				good_nxt = good_r + 4'h1;
			end
		end else if (gap_r == LOCK_GAP_CYC) begin
			good_nxt = 4'h0;
			locked_nxt = 1'b0;
		end else begin
			gap_nxt = gap_r + 11'h001;
		end
		red_nxt = !locked_nxt;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			prev_clk_r <= 1'b0;
			bit_r <= 1'b0;
			gap_r <= 11'h000;
			good_r <= 4'h0;
			locked_r <= 1'b0;
			red_r <= 1'b1;
		end else begin
			prev_clk_r <= prev_clk_nxt;
			bit_r <= bit_nxt;
			gap_r <= gap_nxt;
			good_r <= good_nxt;
			locked_r <= locked_nxt;
			red_r <= red_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Error lamp stretch and error count
	// -----------------------------------------------------------------
	// A lone error is one clock long; the stretch makes it visible on a lamp.
	always_comb begin
		hold_nxt = (hold_r != 23'h0) ? hold_r - 23'h1 : hold_r;
		errcnt_nxt = errcnt_r;
		if (commit && (avs_address == ERRCNT_OFS)) begin
			errcnt_nxt = 16'h0;
		end
		if (decode_error) begin
			hold_nxt = 23'(ERR_HOLD_CYCLES - 1);
			if (errcnt_nxt != 16'hFFFF) begin
				errcnt_nxt = errcnt_nxt + 16'h1;
			end
		end
		err_nxt = decode_error || (hold_r != 23'h0);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			hold_r <= 23'h0;
			errcnt_r <= 16'h0;
			err_r <= 1'b0;
		end else begin
			hold_r <= hold_nxt;
			errcnt_r <= errcnt_nxt;
			err_r <= err_nxt;
		end
	end

	// -----------------------------------------------------------------
	// PCM serializer: 32 bits per frame, left first, MSB first
	// -----------------------------------------------------------------
	// The bit clock rounds slightly fast, so each frame reloads from the
	// newest held pair instead of drifting a queue.
	always_comb begin
		pl_nxt = main_load ? main_left : pl_r;
		pr_nxt = main_load ? main_right : pr_r;
		pdiv_nxt = pdiv_r + 5'h01;
		pclk_nxt = pclk_r;
		psh_nxt = psh_r;
		pbit_nxt = pbit_r;
		if (pdiv_r == PCM_HALF_CYC - 5'h01) begin
			pdiv_nxt = 5'h00;
			pclk_nxt = !pclk_r;
			if (pclk_r) begin
				pbit_nxt = pbit_r + 5'h01;
				psh_nxt = (pbit_r == 5'h1F) ? {pl_r, pr_r} : {psh_r[30:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pl_r <= 16'h0000;
			pr_r <= 16'h0000;
			psh_r <= 32'h0;
			pdiv_r <= 5'h00;
			pbit_r <= 5'h00;
			pclk_r <= 1'b0;
		end else begin
			pl_r <= pl_nxt;
			pr_r <= pr_nxt;
			psh_r <= psh_nxt;
			pdiv_r <= pdiv_nxt;
			pbit_r <= pbit_nxt;
			pclk_r <= pclk_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Interface port selector
	// -----------------------------------------------------------------
	always_comb begin
		id_nxt = 1'b0;
		ic_nxt = 1'b0;
		if_nxt = 1'b0;
		ioe_nxt = 1'b0;
		rel_nxt = 1'b0;
		if (!invalid) begin
			case (mode_r)
				MODE_REPEATER: begin
					ioe_nxt = 1'b1;
					rel_nxt = 1'b1;
					id_nxt = bit_r;
					ic_nxt = !prev_clk_r;
				end
				MODE_AES: begin
					ioe_nxt = 1'b1;
					id_nxt = aes_main;
				end
				MODE_PCM: begin
					ioe_nxt = 1'b1;
					id_nxt = psh_r[31];
					ic_nxt = pclk_r;
					if_nxt = (pbit_r < 5'h10);
				end
				default: begin
					ioe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			{id_r, ic_r, if_r, ioe_r, rel_r} <= 5'h00;
		end else begin
			{id_r, ic_r, if_r, ioe_r, rel_r} <= {id_nxt, ic_nxt, if_nxt, ioe_nxt, rel_nxt};
		end
	end

	// Main AES/EBU leaves in every mode; aux follows its own framer.
	assign aes_main_out = aes_main;
	assign aes_aux_out = aes_aux;
	assign aux_digital = auxdig_r;
	assign intf_data = id_r;
	assign intf_clk = ic_r;
	assign intf_frame = if_r;
	assign intf_oe = ioe_r;
	assign relay_output = rel_r;
	assign channel_data = bit_r;
	assign lock_green = locked_r;
	assign lock_red = red_r;
	assign error_led = err_r;
	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	mode_select_a: assert property (ctrl_wr |=> mode_r == $past(avs_writedata[1:0]))
		else $error("mode not taken from write");
	program_quiet_a: assert property (mode_r == MODE_PROGRAM |=> !intf_oe && !intf_data)
		else $error("program mode drives interface");
	invalid_combo_a: assert property (timing_r && mode_r[0] |=> !intf_oe && !relay_output)
		else $error("invalid combination drives interface");
	repeater_clk_a: assert property (!timing_r && mode_r == MODE_REPEATER |=> intf_clk == !$past(prev_clk_r))
		else $error("repeater clock not passed");
	aes_mirror_a: assert property (mode_r == MODE_AES |=> intf_data == $past(aes_main_out))
		else $error("interface differs from AES output");
	pcm_frame_a: assert property (mode_r == MODE_PCM && !timing_r && pbit_r < 5'h10 |=> intf_frame)
		else $error("PCM frame clock wrong");
	data_invert_a: assert property (!timing_r && clk_edge |=> channel_data == ($past(link_data_s) ^ $past(dinv_r)))
		else $error("data polarity wrong");
	ext_source_a: assert property (timing_r && $past(timing_r) && $rose(ext_clk_s ^ cinv_r)
		|=> channel_data == $past(sel_data))
		else $error("external data not used");
	lock_loss_a: assert property (gap_r == LOCK_GAP_CYC && !clk_edge && !ctrl_wr |=> lock_red)
		else $error("lock kept after gap");
	error_lamp_a: assert property (decode_error |=> error_led [*2])
		else $error("error lamp not lit");
	bus_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");
	repeater_run_c: cover property (relay_output && lock_green && intf_clk);
	pcm_run_c: cover property (intf_oe && $rose(intf_frame));
	aes_run_c: cover property (mode_r == MODE_AES && timing_r && intf_oe);
endmodule

// File: bench/link_source.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Far-side bit source: encoder link or external T1 service unit
// ---------------------------------------------------------------
module link_source (
	input wire logic run,
	input wire logic level,
	input wire logic rand_bits,
	output logic clk,
	output logic data
);
	// Clock runs only within a frame, with data moved on its fall.
	// While idle the data line toggles so that no stale bit survives.
	initial begin
		clk = 1'b0;
		data = 1'b0;
		forever begin
			#80;
			if (run) begin
				clk = ~clk;
				if (!clk) begin
					data = rand_bits ? 1'($urandom) : level;
				end
			end else begin
				clk = 1'b0;
				data = ~data;
			end
		end
	end
endmodule

// File: bench/intf_mode_mux_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module intf_mode_mux_test;
	import stl_dec_pkg::*;
	localparam int HOLD = 20;
	logic clock, rst, avs_read, avs_write, avs_waitrequest, decode_error, main_load, aux_load;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic link_data, link_clk, ext_data, ext_clk, l_run, e_run, lvl, rnd;
	logic [15:0] main_left, main_right, aux_left, aux_right, left_v, pcm;
	logic intf_data, intf_clk, intf_frame, intf_oe, relay_output, aes_main_out, aes_aux_out;
	logic aux_digital, channel_data, lock_green, lock_red, error_led, prev, pc;
	int n_fail, check_count, cnt, n, k;

	intf_mode_mux #(.ERR_HOLD_CYCLES(HOLD)) intf_mode_mux_inst (.clock(clock), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link_data(link_data), .link_clk(link_clk),
		.ext_data(ext_data), .ext_clk(ext_clk), .decode_error(decode_error),
		.main_left(main_left), .main_right(main_right), .main_load(main_load),
		.aux_left(aux_left), .aux_right(aux_right), .aux_load(aux_load), .intf_data(intf_data),
		.intf_clk(intf_clk), .intf_frame(intf_frame), .intf_oe(intf_oe), .relay_output(relay_output),
		.aes_main_out(aes_main_out), .aes_aux_out(aes_aux_out), .aux_digital(aux_digital),
		.channel_data(channel_data), .lock_green(lock_green), .lock_red(lock_red), .error_led(error_led));
	link_source link_inst (.run(l_run), .level(lvl), .rand_bits(rnd), .clk(link_clk), .data(link_data));
	link_source csu_inst (.run(e_run), .level(lvl), .rand_bits(rnd), .clk(ext_clk), .data(ext_data));

	// System clock.
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Sample pairs arrive at the frame rate, as from the source decoders.
	always @(posedge clock) begin
		cnt <= (cnt == 1561) ? 0 : cnt + 1;
		main_load <= (cnt == 0);
		aux_load <= (cnt == 0);
		main_left <= left_v;
	end

	// Expected interface enable: mode 0 and the invalid external combinations stay quiet.
	function automatic logic exp_oe(input logic t, input logic [1:0] m);
		return (m != 2'h0) && !(t && m[0]);
	endfunction

	// Avalon master: the request stands until waitrequest is sampled low.
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		n = 0;
		@(posedge clock);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 40) n_fail++;
	endtask

	// One edge first, so a lock drop launched by the last write is seen.
	task wait_lock(input logic v);
		n = 0;
		@(posedge clock);
		while (lock_green !== v && n < 600) begin
			@(posedge clock);
			n++;
		end
		if (n >= 600) n_fail++;
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under 20000 cycles.
	initial begin
		#400000;
		n_fail++;
		final_report();
	end

	// Main sequence.
	initial begin
		{rst, avs_read, avs_write, decode_error, l_run, e_run, lvl, rnd, cnt} = '0;
		{avs_address, avs_byteenable, avs_writedata, left_v} = '0;
		void'($urandom(32'hF636D877));
		main_right = 16'($urandom);
		aux_left = 16'($urandom);
		aux_right = 16'($urandom);
		rst = 1'b1;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		`CHK("waitrequest", 1'b1, avs_waitrequest)
		`CHK("oe", 1'b0, intf_oe)
		`CHK("lock_red", 1'b1, lock_red)
		// Registers: read back, byte-enable refusal, unmapped place.
		k = $urandom & 32'h3F;
		bus(1'b1, CTRL_OFS, k, 4'hF);
		bus(1'b1, CTRL_OFS, 32'h15, 4'hE);
		bus(1'b0, CTRL_OFS, 32'h0, 4'hF);
		`CHK("ctrl", 32'(k), q)
		`CHK("aux_digital", k[AUXDIG_BIT], aux_digital)
		bus(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
		bus(1'b0, 4'hC, 32'h0, 4'hF);
		`CHK("unmapped", 32'h0, q)
		$display("test registers done");
		// Every mode under both timing sources.
		for (int t = 0; t < 2; t++) begin
			for (int m = 0; m < 4; m++) begin
				bus(1'b1, CTRL_OFS, 32'(t * 4 + m), 4'hF);
				repeat (6) @(posedge clock);
				`CHK("oe", exp_oe(1'(t), 2'(m)), intf_oe)
				`CHK("relay", 1'(m == 1 && t == 0), relay_output)
				if (!intf_oe) `CHK("idle data", 1'b0, intf_data)
				bus(1'b0, STATUS_OFS, 32'h0, 4'hF);
				`CHK("invalid", 1'(t == 1 && m[0]), q[2])
				prev = aes_main_out;
				k = 0;
				repeat (64) begin
					@(posedge clock);
					if (aes_main_out !== prev) k++;
					prev = aes_main_out;
				end
				`CHK("aes active", 1'b1, 1'(k > 0))
			end
		end
		prev = aes_aux_out;
		k = 0;
		repeat (64) begin
			@(posedge clock);
			if (aes_aux_out !== prev) k++;
			prev = aes_aux_out;
		end
		`CHK("aux aes active", 1'b1, 1'(k > 0))
		$display("test modes done");
		// Repeater with each data polarity, then random bits.
		l_run = 1'b1;
		lvl = 1'b1;
		for (int inv = 0; inv < 2; inv++) begin
			bus(1'b1, CTRL_OFS, 32'(1 + inv * 8), 4'hF);
			wait_lock(1'b1);
			repeat (40) @(posedge clock);
			`CHK("locked", 2'b10, {lock_green, lock_red})
			`CHK("polarity", 1'(1 - inv), channel_data)
		end
		rnd = 1'b1;
		prev = channel_data;
		pc = intf_clk;
		k = 0;
		repeat (300) begin
			@(posedge clock);
			`CHK("repeat data", prev, intf_data)
			if (intf_clk !== pc) k++;
			prev = channel_data;
			pc = intf_clk;
		end
		`CHK("repeat clock", 1'b1, 1'(k > 20))
		bus(1'b1, CTRL_OFS, 32'h5, 4'hF);
		repeat (3) @(posedge clock);
		`CHK("lock drop", 1'b1, lock_red)
		bus(1'b1, CTRL_OFS, 32'h1, 4'hF);
		wait_lock(1'b1);
		l_run = 1'b0;
		repeat (1100) @(posedge clock);
		`CHK("gap unlock", 2'b01, {lock_green, lock_red})
		$display("test repeater done");
		// External timing in AES mode, both clock polarities.
		e_run = 1'b1;
		for (int p = 0; p < 2; p++) begin
			bus(1'b1, CTRL_OFS, 32'(6 + p * 16), 4'hF);
			wait_lock(1'b1);
			`CHK("ext lock", 1'b1, lock_green)
		end
		prev = aes_main_out;
		repeat (200) begin
			@(posedge clock);
			`CHK("aes copy", prev, intf_data)
			prev = aes_main_out;
		end
		e_run = 1'b0;
		$display("test external done");
		// PCM: left word MSB first while the frame clock is high.
		left_v = 16'($urandom);
		bus(1'b1, CTRL_OFS, 32'h3, 4'hF);
		// The first rise may be the mode change itself; the third is sure to carry the new pair.
		for (int f = 0; f < 3; f++) begin
			n = 0;
			while (!(intf_frame === 1'b1 && prev === 1'b0) && n < 4000) begin
				prev = intf_frame;
				@(posedge clock);
				n++;
			end
			if (n >= 4000) n_fail++;
			prev = 1'b1;
		end
		k = 0;
		pc = intf_clk;
		while (intf_frame === 1'b1 && k < 40) begin
			@(posedge clock);
			if (intf_clk === 1'b1 && pc === 1'b0 && intf_frame === 1'b1) begin
				pcm = {pcm[14:0], intf_data};
				k++;
			end
			pc = intf_clk;
		end
		`CHK("pcm bits", 16, k)
		`CHK("pcm left", left_v, pcm)
		$display("test pcm done");
		// Error lamp and counter, with a clear afterwards.
		k = 1 + $urandom % 3;
		repeat (k) begin
			@(posedge clock);
			decode_error <= 1'b1;
			@(posedge clock);
			decode_error <= 1'b0;
		end
		#1;
		`CHK("err lamp", 1'b1, error_led)
		repeat (HOLD - 1) @(posedge clock);
		#1;
		`CHK("err held", 1'b1, error_led)
		@(posedge clock);
		#1;
		`CHK("err off", 1'b0, error_led)
		bus(1'b0, ERRCNT_OFS, 32'h0, 4'hF);
		`CHK("errcnt", 32'(k), q)
		bus(1'b1, ERRCNT_OFS, 32'h0, 4'hF);
		bus(1'b0, ERRCNT_OFS, 32'h0, 4'hF);
		`CHK("errclr", 32'h0, q)
		$display("test errors done");
		final_report();
	end
endmodule
